// file: logic/eep_defs.svh
`ifndef EEP_DEFS_SVH
`define EEP_DEFS_SVH

// clock rates
`define EEP_CLK_PERIOD_NS 50
`define EEP_LINK_PERIOD_PS 6000

// power-up ready delay, 0.35 ms, held in ns
`define EEP_PU_DELAY_NS 350000
`define EEP_PU_CYCLES (`EEP_PU_DELAY_NS / `EEP_CLK_PERIOD_NS)

// internal write time, 4 ms, held in ns
`define EEP_WR_TIME_NS 4000000
`define EEP_WR_CYCLES (`EEP_WR_TIME_NS / `EEP_CLK_PERIOD_NS)

// timer width, covers both delays
`define EEP_CNT_W 17

// noise pulse filtered on the bus inputs, 50 ns
`define EEP_GLITCH_NS 50
`define EEP_GLITCH_CNT ((`EEP_GLITCH_NS * 1000) / `EEP_LINK_PERIOD_PS + 1)

// slave address byte layout
`define EEP_DEV_TYPE 4'ha
`define EEP_SA_RW 0
`define EEP_SA_PAGE 1
`define EEP_SA_ALO 2
`define EEP_SA_AHI 3

// array geometry
`define EEP_ADDR_W 9
`define EEP_MEM_WORDS 512
`define EEP_PAGE_BYTES 16

`endif

// file: logic/eep_pkg.sv
package eep_pkg;

	// bus slave states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ACK_A = 4'h2,
		ST_WORD = 4'h3,
		ST_ACK_W = 4'h4,
		ST_WDATA = 4'h5,
		ST_ACK_D = 4'h6,
		ST_RDATA = 4'h7,
		ST_RACK = 4'h8
	} eep_state_e;

	// filtered bus events seen by the slave
	typedef struct packed {
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic sda;
	} eep_bus_s;

	// levels brought into the link domain
	typedef struct packed {
		logic wp;
		logic a_hi;
		logic a_lo;
		logic busy;
		logic ready;
		logic sda;
		logic scl;
	} eep_pins_s;

endpackage

// file: logic/eep_top.sv
`timescale 1ns/1ps
`include "eep_defs.svh"

module eep_top
	import eep_pkg::*;
#(
	parameter int PU_CYCLES = `EEP_PU_CYCLES,
	parameter int WR_CYCLES = `EEP_WR_CYCLES
) (
	// system clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bus sampling clock
	input wire logic link_clk,
	// supply comparator above trigger level
	input wire logic supply_ok,
	// two-wire bus
	input wire logic scl,
	input wire logic sda_line,
	output logic sda_pull,
	output logic sda_oe_n,
	// strap pins
	input wire logic address_select_low,
	input wire logic address_select_high,
	input wire logic write_protect,
	// status
	output logic device_ready,
	output logic write_busy
);

	// system clock domain: supply sync, power-up and write timers
	logic sup_s1_q, sup_s2_q;
	logic cm_s1_q, cm_s2_q, cm_s3_q;
	logic [`EEP_CNT_W-1:0] por_cnt_q, por_cnt_d;
	logic [`EEP_CNT_W-1:0] wr_cnt_q, wr_cnt_d;
	logic por_done_q, por_done_d;
	logic busy_q, busy_d;
	logic rdy_q, rdy_d;
	logic cmt_tgl_q;

	// power-on and write-cycle timers
	always_comb begin
		por_cnt_d = por_cnt_q;
		por_done_d = por_done_q;
		wr_cnt_d = wr_cnt_q;
		busy_d = busy_q;
		if (!sup_s2_q) begin
			// brown-out puts the power-up and write timers back to reset
			por_cnt_d = '0;
			por_done_d = 1'b0;
			busy_d = 1'b0;
			wr_cnt_d = '0;
		end else begin
			if (!por_done_q) begin
				if (por_cnt_q == `EEP_CNT_W'(PU_CYCLES - 1))
					por_done_d = 1'b1;
				else
					por_cnt_d = por_cnt_q + 1'b1;
			end
			if (cm_s2_q ^ cm_s3_q) begin
				busy_d = 1'b1;
				wr_cnt_d = '0;
			end else if (busy_q) begin
				if (wr_cnt_q == `EEP_CNT_W'(WR_CYCLES - 1))
					busy_d = 1'b0;
				else
					wr_cnt_d = wr_cnt_q + 1'b1;
			end
		end
		rdy_d = por_done_d & ~busy_d;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sup_s1_q <= 1'b0;
			sup_s2_q <= 1'b0;
			cm_s1_q <= 1'b0;
			cm_s2_q <= 1'b0;
			cm_s3_q <= 1'b0;
			por_cnt_q <= '0;
			wr_cnt_q <= '0;
			por_done_q <= 1'b0;
			busy_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			sup_s1_q <= supply_ok;
			sup_s2_q <= sup_s1_q;
			cm_s1_q <= cmt_tgl_q; // toggle from the link side
			cm_s2_q <= cm_s1_q;
			cm_s3_q <= cm_s2_q;
			por_cnt_q <= por_cnt_d;
			wr_cnt_q <= wr_cnt_d;
			por_done_q <= por_done_d;
			busy_q <= busy_d;
			rdy_q <= rdy_d;
		end
	end

	assign device_ready = rdy_q;
	assign write_busy = busy_q;

	// link clock domain: filters, bus slave, page buffer and array
	eep_pins_s in_raw, in_s1_q, in_s2_q;
	logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
	logic [4:0] scl_flt, sda_flt;
	logic [3:0] scl_cnt_q, sda_cnt_q;
	eep_bus_s ev;
	eep_state_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [`EEP_ADDR_W-1:0] ptr_q, ptr_d;
	logic [`EEP_PAGE_BYTES-1:0] pmask_q, pmask_d;
	logic wp_lat_q, wp_lat_d;
	logic oe_n_q, oe_n_d;
	logic wait_q, wait_d;
	logic cmt_tgl_d;
	logic pb_we, do_commit, ready_l;
	logic [7:0] rd_byte;
	logic [7:0] mem [`EEP_MEM_WORDS];
	logic [7:0] pbuf [`EEP_PAGE_BYTES];

	// accept a new level only after it outlasts the noise window
	function automatic logic [4:0] flt(input logic raw, input logic filt,
		input logic [3:0] cnt);
		if (raw == filt)
			return {filt, 4'h0};
		else if (cnt == 4'(`EEP_GLITCH_CNT))
			return {raw, 4'h0};
		else
			return {filt, cnt + 4'h1};
	endfunction

	// pull-downs sit on the straps outside; the core sees plain levels
	assign in_raw = '{wp: write_protect, a_hi: address_select_high,
		a_lo: address_select_low, busy: busy_q, ready: por_done_q,
		sda: sda_line, scl: scl};

	assign scl_flt = flt(in_s2_q.scl, scl_f_q, scl_cnt_q);
	assign sda_flt = flt(in_s2_q.sda, sda_f_q, sda_cnt_q);

	// bus events from the filtered levels
	assign ev.rise = scl_f_q & ~scl_p_q;
	assign ev.fall = ~scl_f_q & scl_p_q;
	assign ev.start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
	assign ev.stop = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
	assign ev.sda = sda_f_q;

	// busy seen late across the crossing is covered by wait_q
	assign ready_l = in_s2_q.ready & ~in_s2_q.busy & ~wait_q;
	assign rd_byte = mem[ptr_q];

	// bus slave state machine
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		pmask_d = pmask_q;
		wp_lat_d = wp_lat_q;
		oe_n_d = oe_n_q;
		wait_d = wait_q & ~in_s2_q.busy;
		cmt_tgl_d = cmt_tgl_q;
		pb_we = 1'b0;
		do_commit = 1'b0;
		if (!in_s2_q.ready) begin
			st_d = ST_IDLE;
			oe_n_d = 1'b1;
			pmask_d = '0;
			wait_d = 1'b0;
		end else if (ev.stop) begin
			st_d = ST_IDLE;
			oe_n_d = 1'b1;
			if (pmask_q != '0) begin
				do_commit = 1'b1;
				cmt_tgl_d = ~cmt_tgl_q;
				wait_d = 1'b1;
				pmask_d = '0;
			end
		end else if (ev.start) begin
			// a restart drops any unfinished page
			st_d = ST_ADDR;
			cnt_d = 4'h0;
			oe_n_d = 1'b1;
			pmask_d = '0;
		end else begin
			case (st_q)
			ST_ADDR, ST_WORD, ST_WDATA: begin
				if (ev.rise && cnt_q != 4'h8) begin
					sh_d = {sh_q[6:0], ev.sda};
					cnt_d = cnt_q + 4'h1;
				end else if (ev.fall && cnt_q == 4'h8) begin
					cnt_d = 4'h0;
					st_d = ST_IDLE;
					if (st_q == ST_ADDR) begin
						if (sh_q[7:4] == `EEP_DEV_TYPE &&
							sh_q[`EEP_SA_AHI] == in_s2_q.a_hi &&
							sh_q[`EEP_SA_ALO] == in_s2_q.a_lo &&
							ready_l) begin
							oe_n_d = 1'b0;
							ptr_d[8] = sh_q[`EEP_SA_PAGE];
							st_d = ST_ACK_A;
						end
					end else if (st_q == ST_WORD) begin
						oe_n_d = 1'b0;
						ptr_d[7:0] = sh_q;
						st_d = ST_ACK_W;
					end else if (!wp_lat_q) begin
						oe_n_d = 1'b0;
						pb_we = 1'b1;
						pmask_d[ptr_q[3:0]] = 1'b1;
						ptr_d[3:0] = ptr_q[3:0] + 4'h1; // wraps in page
						st_d = ST_ACK_D;
					end else begin
						pmask_d = '0;
					end
				end
			end
			ST_ACK_A, ST_ACK_W, ST_ACK_D: begin
				if (ev.fall) begin
					oe_n_d = 1'b1;
					cnt_d = 4'h0;
					st_d = ST_WDATA;
					if (st_q == ST_ACK_A) begin
						if (sh_q[`EEP_SA_RW]) begin
							sh_d = rd_byte;
							oe_n_d = rd_byte[7];
							st_d = ST_RDATA;
						end else begin
							st_d = ST_WORD;
						end
					end else if (st_q == ST_ACK_W) begin
						wp_lat_d = in_s2_q.wp;
					end
				end
			end
			ST_RDATA: begin
				if (ev.rise && cnt_q != 4'h8) begin
					cnt_d = cnt_q + 4'h1;
				end else if (ev.fall && cnt_q == 4'h8) begin
					oe_n_d = 1'b1;
					ptr_d = ptr_q + 1'b1;
					cnt_d = 4'h0;
					st_d = ST_RACK;
				end else if (ev.fall && cnt_q != 4'h0) begin
					sh_d = {sh_q[6:0], 1'b0};
					oe_n_d = sh_q[6];
				end
			end
			ST_RACK: begin
				if (ev.rise) begin
					if (ev.sda)
						st_d = ST_IDLE; // master ends the read
					else
						cnt_d = 4'h1;
				end else if (ev.fall && cnt_q == 4'h1) begin
					sh_d = rd_byte;
					oe_n_d = rd_byte[7];
					cnt_d = 4'h0;
					st_d = ST_RDATA;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			in_s1_q <= '0;
			in_s2_q <= '0;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			scl_cnt_q <= 4'h0;
			sda_cnt_q <= 4'h0;
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= '0;
			pmask_q <= '0;
			wp_lat_q <= 1'b0;
			oe_n_q <= 1'b1;
			wait_q <= 1'b0;
			cmt_tgl_q <= 1'b0;
		end else begin
			in_s1_q <= in_raw;
			in_s2_q <= in_s1_q;
			{scl_f_q, scl_cnt_q} <= scl_flt;
			{sda_f_q, sda_cnt_q} <= sda_flt;
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			pmask_q <= pmask_d;
			wp_lat_q <= wp_lat_d;
			oe_n_q <= oe_n_d;
			wait_q <= wait_d;
			cmt_tgl_q <= cmt_tgl_d;
		end
	end

	// page buffer and array; array comes up erased
	always_ff @(posedge link_clk) begin
		if (pb_we)
			pbuf[ptr_q[3:0]] <= sh_q;
		if (do_commit) begin
			for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
				if (pmask_q[i])
					mem[{ptr_q[8:4], 4'(i)}] <= pbuf[i];
			end
		end
	end

	initial begin
		for (int j = 0; j < `EEP_MEM_WORDS; j++)
			mem[j] = 8'hff;
	end

	// open drain: only ever pull low
	assign sda_pull = 1'b0;
	assign sda_oe_n = oe_n_q;

endmodule // eep_top

// file: testbench/eep_checker.sv
`timescale 1ns/1ps
module eep_checker #(
	parameter int PU_CYCLES = 7000
) (
	// clocks and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	// watched pins
	input wire logic supply_ok,
	input wire logic scl,
	input wire logic sda_pull,
	input wire logic sda_oe_n,
	input wire logic device_ready,
	input wire logic write_busy
);
	int sok_q, sok_d;
	// supply-up run length, saturating just past the ready delay
	always_comb sok_d = supply_ok ? sok_q + int'(sok_q < PU_CYCLES + 9) : 0;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sok_q <= 0;
		else
			sok_q <= sok_d;
	end
	// pull value only, the pin is never driven high
	a_pull_zero: assert property (
		@(posedge clk) disable iff (!nrst) sda_pull == 1'b0)
		else $error("sda pull value not zero");
	a_reset_idle: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> sda_oe_n && !device_ready && !write_busy)
		else $error("not idle after reset");
	// two flops of sync plus the ready register
	a_supply_drop: assert property (
		@(posedge clk) disable iff (!nrst)
		(!supply_ok) [*4] |-> !device_ready && !write_busy)
		else $error("still ready with supply down");
	a_ready_in_time: assert property (
		@(posedge clk) disable iff (!nrst)
		(sok_q == PU_CYCLES + 9 && !write_busy) [*3] |-> device_ready)
		else $error("ready delay overrun");
	a_busy_unready: assert property (
		@(posedge clk) disable iff (!nrst) write_busy |-> !device_ready)
		else $error("ready during internal write");
	a_quiet_unready: assert property (
		@(posedge clk) disable iff (!nrst)
		(!device_ready) [*2] |-> sda_oe_n)
		else $error("sda driven while not ready");
	// drive edges must land in the low half of the bus clock
	a_edge_in_low: assert property (
		@(posedge link_clk) disable iff (!nrst)
		$changed(sda_oe_n) |-> !scl)
		else $error("sda drive changed with scl high");
	a_ack_holds: assert property (
		@(posedge link_clk) disable iff (!nrst)
		$fell(sda_oe_n) |-> (!sda_oe_n) [*8])
		else $error("low drive too short");
endmodule // eep_checker

bind eep_top eep_checker #(.PU_CYCLES(PU_CYCLES)) eep_checker_i (
	.clk(clk), .nrst(nrst), .link_clk(link_clk), .supply_ok(supply_ok),
	.scl(scl), .sda_pull(sda_pull), .sda_oe_n(sda_oe_n),
	.device_ready(device_ready), .write_busy(write_busy));

// file: testbench/eep_mst.sv
`timescale 1ns/1ps
module eep_mst (
	// timing reference
	input wire logic clk,
	// resolved data line
	input wire logic sda_w,
	// master drive, data high means released
	output logic scl = 1'b1,
	output logic sda_m = 1'b1
);
	logic gl = 1'b0; // inject 30 ns pulses on scl
	// one bus phase of 0.3 us; clock stands high between frames
	task automatic step(input logic c, input logic s);
		scl <= c;
		sda_m <= s;
		repeat (6) @(posedge clk);
	endtask
	// from scl low this is a repeated start
	task automatic start();
		step(scl, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b1, 1'b1);
	endtask
	// data moves only while scl is low, sampled mid high
	task automatic bit1(input logic b, output logic s);
		if (gl) begin
			#20 scl <= 1'b1;
			#30 scl <= 1'b0;
		end
		step(1'b0, b);
		step(1'b1, b);
		s = sda_w;
		step(1'b1, b);
		step(1'b0, b);
	endtask
	// byte out msb first, gives back the ack level
	task automatic tx(input logic [7:0] d, output logic ak);
		for (int i = 7; i >= 0; i--) bit1(d[i], ak);
		bit1(1'b1, ak);
	endtask
	// byte in; the last one is answered with a nack
	task automatic rx(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
		bit1(last, s);
	endtask
endmodule // eep_mst

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int PU = 20;
	localparam int WR = 400;
	logic clk, link_clk, nrst, supply_ok, write_protect;
	logic sda_o, sda_oe_n, device_ready, write_busy, scl, sda_m;
	logic [1:0] strap;
	logic strap_en;
	// pull-downs on the straps: a released strap must read low
	tri0 [1:0] strap_pin;
	assign strap_pin = strap_en ? strap : 2'bzz;
	logic [7:0] d;
	logic [8:0] ad;
	logic [7:0] mem [512];
	int fail_count, total_checks, seed;
	int cyc = 0;
	// open drain with pull-up: any low wins
	wire sda_w = sda_m & (sda_oe_n | sda_o);
	eep_top #(.PU_CYCLES(PU), .WR_CYCLES(WR)) eep_top_i (
		.clk(clk), .nrst(nrst), .link_clk(link_clk), .supply_ok(supply_ok),
		.scl(scl), .sda_line(sda_w), .sda_pull(sda_o), .sda_oe_n(sda_oe_n),
		.address_select_low(strap_pin[0]),
		.address_select_high(strap_pin[1]),
		.write_protect(write_protect), .device_ready(device_ready),
		.write_busy(write_busy));
	eep_mst eep_mst_i (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
	// clocks; link clock skewed so the edges drift apart
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	// hang guard, well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [7:0] sab(logic [1:0] s, logic pg, logic rw);
		return {4'ha, s, pg, rw};
	endfunction
	// address only; a nack ends it at once
	task automatic probe(input logic [7:0] b, input logic e);
		logic ak;
		eep_mst_i.start();
		eep_mst_i.tx(b, ak);
		eep_mst_i.stop();
		chk("probe ack", {7'h0, e}, {7'h0, ak});
	endtask
	// ready is looked at mid-cycle, where it has settled
	task automatic wait_rdy(input int lim);
		int k;
		k = 0;
		@(negedge clk);
		while (device_ready !== 1'b1 && k < lim) begin
			@(negedge clk);
			k++;
		end
		chk("ready", 8'h1, {7'h0, device_ready});
		@(posedge clk);
	endtask
	// page write; the model wraps inside the page
	task automatic wr(input logic [8:0] a0, input int n, input logic wp);
		logic ak;
		logic [3:0] lo;
		lo = a0[3:0];
		write_protect <= wp;
		eep_mst_i.start();
		eep_mst_i.tx(sab(strap, a0[8], 1'b0), ak);
		chk("addr ack", 8'h0, {7'h0, ak});
		eep_mst_i.tx(a0[7:0], ak);
		chk("word ack", 8'h0, {7'h0, ak});
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			eep_mst_i.tx(d, ak);
			chk("data ack", {7'h0, wp}, {7'h0, ak});
			if (!wp)
				mem[{a0[8:4], lo}] = d;
			lo++;
		end
		eep_mst_i.stop();
	endtask
	// selective read then sequential, against the model
	task automatic rd(input logic [8:0] a0, input int n);
		logic ak;
		logic [8:0] p;
		p = a0;
		eep_mst_i.start();
		eep_mst_i.tx(sab(strap, a0[8], 1'b0), ak);
		eep_mst_i.tx(a0[7:0], ak);
		eep_mst_i.start();
		eep_mst_i.tx(sab(strap, a0[8], 1'b1), ak);
		chk("read ack", 8'h0, {7'h0, ak});
		for (int i = 0; i < n; i++) begin
			eep_mst_i.rx(i == n - 1, d);
			chk("read data", mem[p], d);
			p++;
		end
		eep_mst_i.stop();
	endtask
	initial begin
		nrst = 1'b0;
		supply_ok = 1'b0;
		write_protect = 1'b0;
		strap = 2'h0;
		strap_en = 1'b0; // straps left floating at first
		seed = 32'hbe8a45dc;
		fail_count = 0;
		total_checks = 0;
		for (int i = 0; i < 512; i++) mem[i] = 8'hff;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk("released", 8'h1, {7'h0, sda_oe_n});
		probe(sab(2'h0, 1'b0, 1'b0), 1'b1);
		supply_ok <= 1'b1;
		wait_rdy(PU + 8);
		repeat (20) @(posedge clk);
		// every strap setting, growing pages up to a wrap
		for (int t = 0; t < 4; t++) begin
			strap <= t[1:0];
			strap_en <= (t != 0); // first pass on pull-downs
			ad = 9'($random(seed));
			wr(ad, 1 + t * 6, 1'b0);
			@(negedge clk);
			chk("busy", 8'h1, {7'h0, write_busy});
			@(posedge clk);
			probe(sab(strap, 1'b0, 1'b0), 1'b1);
			wait_rdy(WR + 20);
			probe(sab(~strap, 1'b0, 1'b0), 1'b1);
			rd(ad, 20);
		end
		wr(ad, 1, 1'b1);
		write_protect <= 1'b0;
		wait_rdy(WR + 20);
		rd(ad, 1);
		// short clock pulses must not shift any bit
		eep_mst_i.gl = 1'b1;
		probe(sab(strap, 1'b0, 1'b0), 1'b0);
		eep_mst_i.gl = 1'b0;
		// brown-out, then recovery with the array intact
		supply_ok <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("ready drop", 8'h0, {7'h0, device_ready});
		@(posedge clk);
		probe(sab(strap, 1'b0, 1'b0), 1'b1);
		supply_ok <= 1'b1;
		wait_rdy(PU + 8);
		repeat (20) @(posedge clk);
		rd(ad, 2);
		tally_and_finish();
	end
endmodule // tb_top
